// >>> design/tsp_defines.svh
// Purpose: constants for the serial port pin logic
// Assumes: 100 MHz reference clock
// Notes: rates are given in kHz; increments are truncated by the integer divide
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH
`define TSP_WORD_BITS 16
`define TSP_OWN_SLOTS 6
`define TSP_FRAME_SLOTS 16
`define TSP_REF_KHZ 100000
`define TSP_RATE_LO_KHZ 12288
`define TSP_RATE_HI_KHZ 16384
`define TSP_PIN_BCLK 0
`define TSP_PIN_FS 1
`define TSP_PIN_SDATA 2
`define TSP_PIN_CHAIN 3
`define TSP_PIN_PORTSEL 4
`define TSP_PIN_PWRDN 5
`define TSP_PIN_MASTER 6
`define TSP_PIN_COUNT 7
`endif

// >>> design/tsp_pkg.sv
// Purpose: types shared by the serial port pin logic
// Assumes: nothing beyond the defines header
// Notes: state codes are gray along idle, armed, slots
package tsp_pkg;
  typedef enum logic [1:0] {
    TSP_IDLE  = 2'h0,
    TSP_ARMED = 2'h1,
    TSP_SLOTS = 2'h3
  } tsp_state_t;

  typedef struct packed {
    logic [2:0] slot;
    logic [15:0] data;
  } tsp_word_t;
endpackage

// >>> design/tsp_serial_port.sv
// Purpose: pin level logic of a tdm serial port, master or slave by strap
// Assumes: all pins are asynchronous to i_ref_clk and sampled through three flops
// Notes: master bit clock is a phase accumulator, so its edges jitter by one cycle
`timescale 1ns/1ps
`include "tsp_defines.svh"

module tsp_serial_port #(
  parameter int WORD_BITS = `TSP_WORD_BITS,
  parameter int OWN_SLOTS = `TSP_OWN_SLOTS,
  parameter int FRAME_SLOTS = `TSP_FRAME_SLOTS
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_master_select_pin,
  input wire logic i_port_select_pin,
  input wire logic i_power_down_pin,
  input wire logic i_bit_clock_rate_select,
  input wire logic i_bit_clock_pin,
  output logic o_bit_clock_pin,
  output logic o_bit_clock_oe,
  input wire logic i_frame_sync_pin,
  output logic o_frame_sync_pin,
  output logic o_frame_sync_oe,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  input wire logic i_slot_chain_in,
  output logic o_slot_chain_out,
  input wire logic [15:0] i_tx_word,
  output logic o_tx_take,
  output tsp_pkg::tsp_word_t o_rx,
  output logic o_rx_valid,
  output logic o_frame_start,
  output logic o_master
);
  localparam int FRAME_BITS = FRAME_SLOTS * WORD_BITS;
  localparam int FW = $clog2(FRAME_BITS);
  localparam logic [31:0] INC_LO =
    32'(((64'(`TSP_RATE_LO_KHZ)) << 32) / 64'(`TSP_REF_KHZ));
  localparam logic [31:0] INC_HI =
    32'(((64'(`TSP_RATE_HI_KHZ)) << 32) / 64'(`TSP_REF_KHZ));
  localparam logic [3:0] LAST_BIT = 4'(WORD_BITS - 1);
  localparam logic [2:0] LAST_SLOT = 3'(OWN_SLOTS - 1);

  logic [`TSP_PIN_COUNT-1:0] pins;
  logic [`TSP_PIN_COUNT-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic master_ff, rate_ff, bclk_prev_ff, fs_ff, nxt_fs;
  logic [31:0] acc_ff, nxt_acc, inc;
  logic [FW-1:0] frm_ff, nxt_frm;
  logic active, bypass, bclk_lvl, rise, fall, start;
  tsp_pkg::tsp_state_t state_ff, nxt_state;
  logic [3:0] bit_ff, nxt_bit;
  logic [2:0] slot_ff, nxt_slot;
  logic [15:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh;
  logic sdo_ff, nxt_sdo, chain_ff, nxt_chain, take_ff, nxt_take;
  logic rxv_ff, nxt_rxv, fstart_ff, nxt_fstart;
  tsp_pkg::tsp_word_t rx_ff, nxt_rx;

  // pin synchronisers, a change counts once stages two and three agree
  assign pins = {i_master_select_pin, i_power_down_pin, i_port_select_pin,
                 i_slot_chain_in, i_serial_in_pin, i_frame_sync_pin, i_bit_clock_pin};
  for (genvar g = 0; g < `TSP_PIN_COUNT; g++) begin : g_sync
    always_ff @(posedge i_ref_clk) begin
      s1_ff[g] <= pins[g];
      s2_ff[g] <= s1_ff[g];
      s3_ff[g] <= s2_ff[g];
      filt_ff[g] <= (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : filt_ff[g];
    end
  end

  assign active = filt_ff[`TSP_PIN_PORTSEL] & ~filt_ff[`TSP_PIN_PWRDN];
  assign bypass = ~filt_ff[`TSP_PIN_PORTSEL] | filt_ff[`TSP_PIN_PWRDN];
  assign inc = rate_ff ? INC_HI : INC_LO;
  assign bclk_lvl = master_ff ? acc_ff[31] : filt_ff[`TSP_PIN_BCLK];
  assign rise = bclk_lvl & ~bclk_prev_ff;
  assign fall = ~bclk_lvl & bclk_prev_ff;
  // master starts on own sync, slave on chain input
  assign start = fall & (master_ff ? fs_ff : filt_ff[`TSP_PIN_CHAIN]);

  // master clock and frame sync next values
  always_comb begin
    nxt_acc = (master_ff && active) ? acc_ff + inc : 32'h0000_0000;
    nxt_frm = frm_ff;
    nxt_fs = fs_ff;
    if (!(master_ff && active)) begin
      nxt_frm = '0;
      nxt_fs = 1'b0;
    end else if (rise) begin
      nxt_frm = (frm_ff == FW'(FRAME_BITS - 1)) ? '0 : frm_ff + FW'(1);
      nxt_fs = (frm_ff == FW'(FRAME_BITS - 1));
    end
  end

  // strap capture and clock registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      // strap caught while reset is held
      master_ff <= filt_ff[`TSP_PIN_MASTER];
      rate_ff <= 1'b0;
      acc_ff <= 32'h0000_0000;
      frm_ff <= '0;
      fs_ff <= 1'b0;
      bclk_prev_ff <= 1'b0;
    end else begin
      rate_ff <= i_bit_clock_rate_select;
      acc_ff <= nxt_acc;
      frm_ff <= nxt_frm;
      fs_ff <= nxt_fs;
      bclk_prev_ff <= bclk_lvl;
    end
  end

  // slot engine next values
  always_comb begin
    nxt_state = state_ff;
    nxt_bit = bit_ff;
    nxt_slot = slot_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_sdo = sdo_ff;
    nxt_chain = chain_ff;
    nxt_take = 1'b0;
    nxt_rxv = 1'b0;
    nxt_rx = rx_ff;
    nxt_fstart = fall & (master_ff ? fs_ff : filt_ff[`TSP_PIN_FS]);
    // in slave mode chain out marks the final bit period
    if (rise) begin
      nxt_chain = (state_ff == tsp_pkg::TSP_SLOTS) && slot_ff == LAST_SLOT
                  && bit_ff == LAST_BIT && !master_ff;
    end
    case (state_ff)
      tsp_pkg::TSP_IDLE: begin
        if (start) begin
          nxt_state = tsp_pkg::TSP_ARMED;
          nxt_tx_sh = i_tx_word;
          nxt_take = 1'b1;
        end
      end
      tsp_pkg::TSP_ARMED: begin
        if (rise) begin
          nxt_state = tsp_pkg::TSP_SLOTS;
          nxt_bit = 4'h0;
          nxt_slot = 3'h0;
          nxt_sdo = tx_sh_ff[15];
        end
      end
      tsp_pkg::TSP_SLOTS: begin
        // msb leads on each rising edge
        if (rise) begin
          nxt_sdo = tx_sh_ff[15];
        end
        // shift in msb first on falling edge
        if (fall) begin
          nxt_rx_sh = {rx_sh_ff[14:0], filt_ff[`TSP_PIN_SDATA]};
          nxt_tx_sh = {tx_sh_ff[14:0], 1'b0};
          nxt_bit = bit_ff + 4'h1;
          if (bit_ff == LAST_BIT) begin
            nxt_bit = 4'h0;
            nxt_rxv = 1'b1;
            nxt_rx = '{slot: slot_ff, data: {rx_sh_ff[14:0], filt_ff[`TSP_PIN_SDATA]}};
            if (slot_ff == LAST_SLOT) begin
              nxt_state = tsp_pkg::TSP_IDLE;
            end else begin
              nxt_slot = slot_ff + 3'h1;
              nxt_tx_sh = i_tx_word;
              nxt_take = 1'b1;
            end
          end
        end
      end
      default: nxt_state = tsp_pkg::TSP_IDLE;
    endcase
    if (!active) begin
      nxt_state = tsp_pkg::TSP_IDLE;
      nxt_chain = 1'b0;
      nxt_take = 1'b0;
      nxt_rxv = 1'b0;
      nxt_fstart = 1'b0;
    end
  end

  // slot engine registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_ff <= tsp_pkg::TSP_IDLE;
      bit_ff <= 4'h0;
      slot_ff <= 3'h0;
      tx_sh_ff <= 16'h0000;
      rx_sh_ff <= 16'h0000;
      sdo_ff <= 1'b0;
      chain_ff <= 1'b0;
      take_ff <= 1'b0;
      rxv_ff <= 1'b0;
      rx_ff <= '0;
      fstart_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_ff <= nxt_bit;
      slot_ff <= nxt_slot;
      tx_sh_ff <= nxt_tx_sh;
      rx_sh_ff <= nxt_rx_sh;
      sdo_ff <= nxt_sdo;
      chain_ff <= nxt_chain;
      take_ff <= nxt_take;
      rxv_ff <= nxt_rxv;
      rx_ff <= nxt_rx;
      fstart_ff <= nxt_fstart;
    end
  end

  // master drives clock and sync while selected and not powered down
  assign o_bit_clock_pin = acc_ff[31];
  assign o_bit_clock_oe = master_ff & active;
  assign o_frame_sync_pin = fs_ff;
  assign o_frame_sync_oe = master_ff & active;
  assign o_serial_out_pin = sdo_ff;
  assign o_serial_out_oe = (state_ff == tsp_pkg::TSP_SLOTS) & active;
  // bypass copies chain input straight through
  assign o_slot_chain_out = bypass ? i_slot_chain_in : chain_ff;
  assign o_tx_take = take_ff;
  assign o_rx = rx_ff;
  assign o_rx_valid = rxv_ff;
  assign o_frame_start = fstart_ff;
  assign o_master = master_ff;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_clk_drive_oe: assert property (o_bit_clock_oe == (master_ff && active))
    else $error("bit clock enable not tied to strap and select");
  a_nco_step: assert property ($past(master_ff && active) && $past(i_resetn)
    |-> acc_ff == $past(acc_ff) + (($past(rate_ff)) ? INC_HI : INC_LO))
    else $error("bit clock step does not match rate");
  a_sync_drive_oe: assert property (master_ff && active |-> o_frame_sync_oe)
    else $error("master not driving frame sync");
  a_rx_msb_order: assert property (o_rx_valid
    |-> o_rx.data == $past(nxt_rx_sh) && $past(bit_ff) == LAST_BIT)
    else $error("received word not sixteen bits msb first");
  a_tx_msb_lead: assert property (state_ff == tsp_pkg::TSP_SLOTS && rise && active
    |=> o_serial_out_pin == $past(tx_sh_ff[15]))
    else $error("serial output bit not msb of shifter");
  a_out_release: assert property (state_ff != tsp_pkg::TSP_SLOTS |-> !o_serial_out_oe)
    else $error("serial output driven outside own slots");
  a_deselect_quiet: assert property (!active
    |-> !o_bit_clock_oe && !o_frame_sync_oe && !o_serial_out_oe)
    else $error("pins driven while deselected");
  a_arm_start: assert property (state_ff == tsp_pkg::TSP_ARMED && rise && active
    |=> state_ff == tsp_pkg::TSP_SLOTS && bit_ff == 4'h0 && slot_ff == 3'h0)
    else $error("claimed slots did not start on next period");
  a_chain_last: assert property ($rose(chain_ff)
    |-> $past(slot_ff) == LAST_SLOT && $past(bit_ff) == LAST_BIT)
    else $error("chain out not on last bit");
  a_chain_bypass: assert property (bypass |-> o_slot_chain_out == i_slot_chain_in)
    else $error("chain out does not follow chain in");
  a_rate_default: assert property ($past(!i_resetn) |-> !rate_ff)
    else $error("rate not slow after reset");

  c_master_frame: cover property (master_ff && $rose(fs_ff));
  c_slave_claim: cover property (!master_ff && $rose(chain_ff));
  c_rx_word: cover property (o_rx_valid && o_rx.slot == LAST_SLOT);
endmodule // tsp_serial_port

// >>> testbench/tsp_host_model.sv
// Purpose: host serial port model for slave-mode frames
// Assumes: device strapped as slave while frames run
// Notes: bit clock stands still between frames
`timescale 1ns/1ps
module tsp_host_model (
  output logic o_bclk,
  output logic o_fs,
  output logic o_chain,
  output logic o_sdata,
  input wire logic i_sdata,
  input wire logic i_sdata_oe,
  input wire logic i_chain
);
  // host never masters; clock idles low
  initial begin
    o_bclk = 1'b0;
    o_fs = 1'b0;
    o_chain = 1'b0;
    o_sdata = 1'b0;
  end
  // claim period, 96 data periods, one trailing period
  task automatic run_frame(input logic [95:0] tx, output logic [95:0] rx,
      output logic [1:0] ch, output logic oe_ok);
    oe_ok = 1'b1;
    for (int p = 0; p < 98; p++) begin
      o_bclk <= 1'b1;
      o_fs <= (p == 0);
      o_chain <= (p == 0);
      // sent msb first, launched on the rising edge
      if (p >= 1 && p <= 96) o_sdata <= tx[96-p];
      #62.4;
      // device output taken just before the falling edge
      if (p >= 1 && p <= 96) begin
        rx[96-p] = i_sdata;
        oe_ok = oe_ok & i_sdata_oe;
      end
      if (p == 95) ch[0] = i_chain;
      if (p == 96) ch[1] = i_chain;
      #0.1;
      o_bclk <= 1'b0;
      #62.5;
    end
    o_fs <= 1'b0;
    // serial input left at the inverse of its last bit
    o_sdata <= ~o_sdata;
  endtask
endmodule // tsp_host_model

// >>> testbench/tsp_serial_port_test.sv
// Purpose: self-checking bench for the serial port pin logic
// Assumes: 100 MHz ref clock, host bit clock 125 ns
// Notes: txq holds expected tx words, rxq holds the words received
`timescale 1ns/1ps
module tsp_serial_port_test;
  logic clk, rstn, strap, psel, pdn, rate, b_chain;
  logic [15:0] tx_word;
  logic bc_o, bc_oe, fs_o, fs_oe, so, so_oe, co, take, rxv, fstart, mst;
  tsp_pkg::tsp_word_t rx;
  logic h_bclk, h_fs, h_chain, h_sd;
  logic [15:0] txq[$];
  tsp_pkg::tsp_word_t rxq[$];
  int tk, fsn, fail_count, checks;
  logic [31:0] seed;
  wire logic bclk_w = bc_oe ? bc_o : h_bclk;
  wire logic fs_w = fs_oe ? fs_o : h_fs;
  wire logic chain_w = h_chain | b_chain;
  // released serial output shows the inverse of its last level
  wire logic sd_line = so_oe ? so : ~so;
  tsp_serial_port u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_master_select_pin(strap),
    .i_port_select_pin(psel), .i_power_down_pin(pdn), .i_bit_clock_rate_select(rate),
    .i_bit_clock_pin(bclk_w), .o_bit_clock_pin(bc_o), .o_bit_clock_oe(bc_oe),
    .i_frame_sync_pin(fs_w), .o_frame_sync_pin(fs_o), .o_frame_sync_oe(fs_oe),
    .i_serial_in_pin(h_sd), .o_serial_out_pin(so), .o_serial_out_oe(so_oe),
    .i_slot_chain_in(chain_w), .o_slot_chain_out(co), .i_tx_word(tx_word),
    .o_tx_take(take), .o_rx(rx), .o_rx_valid(rxv), .o_frame_start(fstart), .o_master(mst));
  tsp_host_model u_host (.o_bclk(h_bclk), .o_fs(h_fs), .o_chain(h_chain), .o_sdata(h_sd),
    .i_sdata(sd_line), .i_sdata_oe(so_oe), .i_chain(co));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // collect words and feed the next tx word
  always @(posedge clk) begin
    if (rxv === 1'b1) rxq.push_back(rx);
    if (fstart === 1'b1) fsn <= fsn + 1;
    if (take === 1'b1) begin
      tk <= tk + 1;
      tx_word <= (tk + 1 < txq.size()) ? txq[tk+1] : 16'h0000;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // strap only moves while reset is held
  task automatic do_reset(input logic s);
    rstn <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic frame(input logic exp_rx);
    logic [95:0] hb, got;
    logic [1:0] ch;
    logic ok;
    txq.delete();
    rxq.delete();
    for (int i = 0; i < 8; i++) txq.push_back(16'($random(seed)));
    for (int i = 0; i < 6; i++) hb[95-16*i -: 16] = 16'($random(seed));
    @(posedge clk);
    tk <= 0;
    fsn <= 0;
    tx_word <= txq[0];
    u_host.run_frame(hb, got, ch, ok);
    repeat (20) @(posedge clk);
    check("rx_count", rxq.size(), exp_rx ? 6 : 0);
    check("tx_takes", tk, exp_rx ? 6 : 0);
    check("frame_start", fsn, exp_rx ? 1 : 0);
    if (exp_rx) begin
      check("bclk_oe", bc_oe, 0);
      check("fs_oe", fs_oe, 0);
      check("oe_in_slots", ok, 1);
      check("oe_after", so_oe, 0);
      check("chain_out", ch, 2'h2);
      for (int i = 0; i < 6; i++) begin
        check("tx_word", got[95-16*i -: 16], txq[i]);
        check("rx_word", rxq[i], {3'(i), hb[95-16*i -: 16]});
      end
    end
    $display("frame done");
  endtask
  initial begin
    int n, f;
    logic pb;
    seed = 32'h0556;
    {rstn, strap, pdn, rate, b_chain} = 5'h00;
    psel = 1'b1;
    tx_word = 16'h0000;
    tk = 0;
    fsn = 0;
    do_reset(1'b0);
    check("master", mst, 0);
    check("oe_reset", so_oe, 0);
    frame(1'b1);
    frame(1'b1);
    // bypass: deselected, then powered down
    for (int m = 0; m < 2; m++) begin
      psel <= m[0];
      pdn <= m[0];
      repeat (6) @(posedge clk);
      for (int v = 0; v < 2; v++) begin
        b_chain <= v[0];
        repeat (2) @(posedge clk);
        check("chain_bypass", co, v);
      end
      b_chain <= 1'b0;
      check("pins_off", {bc_oe, fs_oe, so_oe}, 0);
      if (m == 0) frame(1'b0);
    end
    psel <= 1'b1;
    pdn <= 1'b0;
    $display("bypass done");
    do_reset(1'b1);
    check("master", mst, 1);
    check("drive_oe", {bc_oe, fs_oe}, 2'h3);
    for (int r = 0; r < 2; r++) begin
      rate <= r[0];
      repeat (10) @(posedge clk);
      n = 0;
      f = 0;
      pb = bc_o;
      // 100 us window: rising bit clock edges and 256-bit frames
      repeat (10000) begin
        @(posedge clk);
        #1;
        if (bc_o && !pb) n++;
        if (fstart === 1'b1) f++;
        pb = bc_o;
      end
      check("bclk_rate", (n >= (r ? 1638 : 1228)) && (n <= (r ? 1639 : 1229)), 1);
      check("frame_count", (f >= (r ? 6 : 4)) && (f <= (r ? 7 : 5)), 1);
    end
    $display("master done");
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule // tsp_serial_port_test
